// [csc_defs.svh]
// Constants for the CPU state and mode controller.
// Assumes a byte-addressed 8-bit register port, one word per register.
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH
// Fixed reset entry address.
`define CSC_RESET_VEC 32'ha0000000
// Register byte offsets.
`define CSC_OFS_CTRL  8'h00
`define CSC_OFS_STATE 8'h04
`define CSC_OFS_SW    8'h08
`define CSC_OFS_VBR   8'h0c
`define CSC_OFS_SAVED_PC 8'h10
`define CSC_OFS_SSW   8'h14
`define CSC_OFS_ISTAT 8'h18
`define CSC_OFS_IMASK 8'h1c
// Field positions.
`define CSC_PRIV_BIT  30
`define CSC_CTRL_PD   0
`define CSC_CTRL_STBY 1
// Reset values.
`define CSC_SW_RST    32'h40000000
`define CSC_VBR_RST   32'h00000000
// Idle pin levels {bus request, manual reset, power-on reset}.
`define CSC_PIN_IDLE  3'b011
// Vector offset used for a privilege violation.
`define CSC_VIOL_OFS  32'h00000100
// Interrupt status bits.
`define CSC_EV_RST    0
`define CSC_EV_EXC    1
`define CSC_EV_VIOL   2
`define CSC_EV_BUS    3
`endif

// [csc_pkg.sv]
// Types shared by the CPU state and mode controller.
// Assumes csc_defs.svh is on the include path.
package csc_pkg;
	// Processor states.
	typedef enum logic [2:0] {
		ST_RESET, ST_EXC, ST_BUSREL, ST_EXEC, ST_PDOWN
	} cpu_state_t;
	// Kind of the reset in force.
	typedef enum logic {RK_POWER_ON, RK_MANUAL} reset_kind_t;
	// Whole register state of the controller.
	typedef struct packed {
		logic [2:0][2:0] sync;
		logic [2:0]      pin;
		cpu_state_t      state;
		reset_kind_t     kind;
		logic [1:0]      ctrl;
		logic [31:0]     sw;
		logic [31:0]     vbr;
		logic [31:0]     saved_pc;
		logic [31:0]     ssw;
		logic [31:0]     pc_tgt;
		logic            pc_load;
		logic            viol_pend;
		logic [3:0]      istat;
		logic [3:0]      imask;
		logic [31:0]     rdata;
	} csc_state_t;
endpackage

// [cpu_state_ctrl.sv]
// CPU processor-state and privilege-mode controller.
// Assumes one 100 MHz clock, reset pins and bus request from outside,
// and exception requests and PC from the core on the same clock.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "csc_defs.svh"

// How it works
// [RL1] Five processor states only.
// [RL2] Power-on reset pin low holds reset.
// [RL3] Manual reset pin low holds reset.
// [RL4] Power-on reset clears all peripherals.
// [RL5] Manual reset spares bus controller registers.
// [RL6] Reset exits to fixed entry address.
// [RL7] Exception saves PC and status word.
// [RL8] Handler address is base plus offset.
// [RL9] Exception state lasts one cycle.
// [RL10] Execution state runs instructions in order.
// [RL11] Power-down halts; sleep or standby.
// [RL12] Bus released while requester holds it.
// [RL13] Privilege bit selects user or privileged.
// [RL14] Reset or exception sets privilege bit.
// [RL15] Exception return clears privilege bit.
// [RL16] Some registers need privileged mode.
// [RL17] User access to them raises exception.
// [RL18] Any reset wins; power-on beats manual.
module cpu_state_ctrl (
	input  wire logic               clk_i,
	input  wire logic               nrst_i,
	input  wire logic               power_on_reset_n_i,
	input  wire logic               manual_reset_n_i,
	input  wire logic               bus_req_i,
	input  wire logic               wake_i,
	input  wire logic               exc_req_i,
	input  wire logic [31:0]        exc_ofs_i,
	input  wire logic               exc_return_i,
	input  wire logic [31:0]        pc_i,
	input  wire logic [7:0]         addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               we_i,
	input  wire logic               re_i,
	output logic [31:0]             rdata_o,
	output csc_pkg::cpu_state_t     state_o,
	output logic                    privilege_bit_o,
	output logic                    exec_en_o,
	output logic                    sleep_o,
	output logic                    standby_o,
	output logic                    bus_grant_o,
	output logic                    periph_rst_o,
	output logic                    external_bus_controller_rst_o,
	output logic                    pc_load_o,
	output logic [31:0]             pc_target_o,
	output logic                    irq_o
);
	import csc_pkg::*;

	// Present and next state.
	csc_state_t q;
	csc_state_t d;
	// Filtered pins, with names.
	logic       por_n;
	logic       man_n;
	logic       bus_req;
	// Privileged mode now.
	logic       priv;
	// A bus access that user mode may not make.
	logic       deny;
	// Events that set status bits this cycle.
	logic [3:0] ev;

	// Tells whether a register needs privileged mode.
	// Only the state register is open to user mode.
	function automatic logic needs_priv(input logic [7:0] a);
		needs_priv = (a != `CSC_OFS_STATE);
	endfunction

	assign por_n   = q.pin[0];
	assign man_n   = q.pin[1];
	assign bus_req = q.pin[2];
	// The privilege bit sets the mode: one is privileged.
	assign priv    = q.sw[`CSC_PRIV_BIT]; // see RL13
	// User-mode access to a guarded register is refused.
	assign deny    = (we_i || re_i) && needs_priv(addr_i) && !priv; // see RL16

	// Works out the whole next state.
	always_comb begin
		d = q;
		ev = 4'h0;
		d.pc_load = 1'b0;
		d.rdata = 32'h0;

		// Three-stage pin synchronisers; a level counts once
		// stages two and three agree.
		d.sync[0] = {bus_req_i, manual_reset_n_i, power_on_reset_n_i};
		d.sync[1] = q.sync[0];
		d.sync[2] = q.sync[1];
		for (int i = 0; i < 3; i++) begin
			if (q.sync[1][i] == q.sync[2][i]) begin
				d.pin[i] = q.sync[2][i];
			end
		end

		// A refused access is remembered as a pending exception.
		if (deny) begin
			d.viol_pend = 1'b1; // see RL17
			ev[`CSC_EV_VIOL] = 1'b1;
		end

		// Register writes, only when allowed.
		if (we_i && !deny) begin
			unique case (addr_i)
				`CSC_OFS_CTRL: begin
					d.ctrl = wdata_i[1:0];
				end
				`CSC_OFS_SW: begin
					d.sw = wdata_i;
				end
				`CSC_OFS_VBR: begin
					d.vbr = wdata_i;
				end
				`CSC_OFS_SAVED_PC: begin
					d.saved_pc = wdata_i;
				end
				`CSC_OFS_SSW: begin
					d.ssw = wdata_i;
				end
				`CSC_OFS_ISTAT: begin
					// Writing one clears a status bit.
					d.istat = q.istat & ~wdata_i[3:0];
				end
				`CSC_OFS_IMASK: begin
					d.imask = wdata_i[3:0];
				end
				default: begin
					// Unmapped or read-only: ignored.
				end
			endcase
		end

		// Register reads; refused or unmapped reads give zero.
		if (re_i && !deny) begin
			unique case (addr_i)
				`CSC_OFS_CTRL: begin
					d.rdata = {30'h0, q.ctrl};
				end
				`CSC_OFS_STATE: begin
					d.rdata = {27'h0, q.kind, 1'b0, q.state};
				end
				`CSC_OFS_SW: begin
					d.rdata = q.sw;
				end
				`CSC_OFS_VBR: begin
					d.rdata = q.vbr;
				end
				`CSC_OFS_SAVED_PC: begin
					d.rdata = q.saved_pc;
				end
				`CSC_OFS_SSW: begin
					d.rdata = q.ssw;
				end
				`CSC_OFS_ISTAT: begin
					d.rdata = {28'h0, q.istat};
				end
				`CSC_OFS_IMASK: begin
					d.rdata = {28'h0, q.imask};
				end
				default: begin
					d.rdata = 32'h0;
				end
			endcase
		end

		// Processor state flow.
		unique case (q.state) // see RL1
			ST_RESET: begin
				// Leave reset once both pins are high.
				if (por_n && man_n) begin
					d.state = ST_EXC;
					d.pc_tgt = `CSC_RESET_VEC; // see RL6
					d.pc_load = 1'b1;
					ev[`CSC_EV_RST] = 1'b1;
				end
			end
			ST_EXC: begin
				// Transient: always on to execution.
				d.state = ST_EXEC; // see RL9
			end
			ST_EXEC: begin
				if (bus_req) begin
					// Hand the bus to the requester.
					d.state = ST_BUSREL; // see RL12
					ev[`CSC_EV_BUS] = 1'b1;
				end else if (exc_req_i || q.viol_pend) begin
					d.state = ST_EXC;
					d.saved_pc = pc_i; // see RL7
					d.ssw = q.sw; // see RL7
					d.sw[`CSC_PRIV_BIT] = 1'b1; // see RL14
					d.pc_tgt = q.vbr + (q.viol_pend ?
						`CSC_VIOL_OFS : exc_ofs_i); // see RL8
					d.pc_load = 1'b1;
					// A violation raised in this very cycle stays pending.
					d.viol_pend = deny; // see RL17
					ev[`CSC_EV_EXC] = 1'b1;
				end else if (q.ctrl[`CSC_CTRL_PD]) begin
					// Halt; the standby bit picks the sub-mode.
					d.state = ST_PDOWN; // see RL11
					d.ctrl[`CSC_CTRL_PD] = 1'b0;
				end else if (exc_return_i) begin
					// Handler done: back to user mode.
					d.sw[`CSC_PRIV_BIT] = 1'b0; // see RL15
					d.pc_tgt = q.saved_pc;
					d.pc_load = 1'b1;
				end
			end
			ST_BUSREL: begin
				// Stay released while the request stands.
				if (!bus_req) begin
					d.state = ST_EXEC; // see RL12
				end
			end
			ST_PDOWN: begin
				if (exc_req_i) begin
					d.state = ST_EXC;
					d.saved_pc = pc_i;
					d.ssw = q.sw;
					d.sw[`CSC_PRIV_BIT] = 1'b1;
					d.pc_tgt = q.vbr + exc_ofs_i;
					d.pc_load = 1'b1;
					ev[`CSC_EV_EXC] = 1'b1;
				end else if (wake_i) begin
					d.state = ST_EXEC;
				end
			end
		endcase

		// A reset pin forces reset from any state; power-on first.
		if (!por_n || !man_n) begin
			d.state = ST_RESET; // see RL18
			d.kind = por_n ? RK_MANUAL : RK_POWER_ON; // see RL2 see RL3
			d.sw = `CSC_SW_RST; // see RL14
			d.vbr = `CSC_VBR_RST;
			d.ctrl = 2'h0;
			d.viol_pend = 1'b0;
			d.pc_load = 1'b0;
		end

		// Events set status bits; a set wins over a clear.
		d.istat = d.istat | ev;
	end

	// Registers the whole state.
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '0;
			// Synchronisers start at the idle pin levels, so that no
			// false bus request or reset edge follows the release.
			q.sync <= {3{`CSC_PIN_IDLE}};
			q.pin <= `CSC_PIN_IDLE;
			q.state <= ST_RESET;
			q.kind <= RK_POWER_ON;
			q.sw <= `CSC_SW_RST;
			q.vbr <= `CSC_VBR_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs, decoded from registered state.
	assign rdata_o         = q.rdata;
	assign state_o         = q.state;
	assign privilege_bit_o = priv;
	assign exec_en_o       = (q.state == ST_EXEC); // see RL10
	assign sleep_o         = (q.state == ST_PDOWN) && !q.ctrl[`CSC_CTRL_STBY];
	assign standby_o       = (q.state == ST_PDOWN) && q.ctrl[`CSC_CTRL_STBY];
	assign bus_grant_o     = (q.state == ST_BUSREL);
	assign periph_rst_o    = (q.state == ST_RESET); // see RL4 see RL5
	assign external_bus_controller_rst_o = (q.state == ST_RESET)
		&& (q.kind == RK_POWER_ON); // see RL5
	assign pc_load_o       = q.pc_load;
	assign pc_target_o     = q.pc_tgt;
	assign irq_o           = |(q.istat & q.imask);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// Reset released into the exception state.
	sequence s_reset_exit;
		q.state == ST_RESET ##1 q.state == ST_EXC;
	endsequence

	// Exception taken from execution, no reset or bus request.
	sequence s_exc_take;
		q.state == ST_EXEC && !bus_req && exc_req_i && !q.viol_pend
			&& d.state == ST_EXC;
	endsequence

	a_state_legal: assert property ( // see RL1
		q.state inside {ST_RESET, ST_EXC, ST_BUSREL, ST_EXEC, ST_PDOWN})
		else $error("Illegal processor state.");

	a_por_hold: assert property ( // see RL2
		!por_n |=> q.state == ST_RESET && q.kind == RK_POWER_ON)
		else $error("Power-on reset not held.");

	a_man_hold: assert property ( // see RL3
		por_n && !man_n |=> q.state == ST_RESET && q.kind == RK_MANUAL)
		else $error("Manual reset not held.");

	a_por_periph: assert property ( // see RL4
		q.state == ST_RESET && q.kind == RK_POWER_ON
			|-> periph_rst_o && external_bus_controller_rst_o)
		else $error("Power-on reset misses a peripheral.");

	a_man_spare: assert property ( // see RL5
		q.state == ST_RESET && q.kind == RK_MANUAL
			|-> periph_rst_o && !external_bus_controller_rst_o)
		else $error("Manual reset touched bus controller.");

	a_reset_vec: assert property ( // see RL6
		s_reset_exit |-> pc_load_o && pc_target_o == `CSC_RESET_VEC)
		else $error("Reset entry address wrong.");

	a_exc_save: assert property ( // see RL7
		s_exc_take |=> q.saved_pc == $past(pc_i) && q.ssw == $past(q.sw))
		else $error("Exception did not save PC and status.");

	a_exc_target: assert property ( // see RL8
		s_exc_take |=> pc_load_o
			&& pc_target_o == $past(q.vbr) + $past(exc_ofs_i))
		else $error("Handler address wrong.");

	a_exc_short: assert property ( // see RL9
		q.state == ST_EXC && d.pin[1:0] == 2'b11 |=> q.state == ST_EXEC)
		else $error("Exception state not transient.");

	a_pd_halt: assert property ( // see RL10 see RL11
		q.state == ST_PDOWN |-> !exec_en_o && (sleep_o != standby_o))
		else $error("Power-down still executing.");

	a_bus_held: assert property ( // see RL12
		q.state == ST_BUSREL && bus_req && d.pin[1:0] == 2'b11
			|=> bus_grant_o)
		else $error("Bus taken back too early.");

	a_bus_entry: assert property ( // see RL12
		q.state == ST_EXEC && bus_req && por_n && man_n |=> bus_grant_o)
		else $error("Bus request not honoured.");

	a_viol_target: assert property ( // see RL17
		q.state == ST_EXEC && q.viol_pend && !bus_req && por_n && man_n
			|=> pc_load_o && pc_target_o == $past(q.vbr) + `CSC_VIOL_OFS)
		else $error("Violation handler address wrong.");

	a_priv_entry: assert property ( // see RL13 see RL14
		q.state == ST_EXC || q.state == ST_RESET |-> privilege_bit_o)
		else $error("Privilege bit clear on entry.");

	a_priv_return: assert property ( // see RL15
		q.state == ST_EXEC && d.state == ST_EXEC && exc_return_i
			&& !exc_req_i && !q.viol_pend && !q.ctrl[0]
			&& !(we_i && addr_i == `CSC_OFS_SW)
			|=> !privilege_bit_o)
		else $error("Privilege bit not cleared on return.");

	a_user_deny: assert property ( // see RL16 see RL17
		deny && por_n && man_n
			|=> (q.viol_pend || q.state == ST_EXC) && rdata_o == 32'h0)
		else $error("User access not refused.");

	a_reset_wins: assert property ( // see RL18
		!por_n && !man_n |=> q.kind == RK_POWER_ON)
		else $error("Manual reset beat power-on.");
endmodule
`default_nettype wire

// [reset_bus_partner.sv]
// Model of the reset sources and the bus requester beside the controller.
// Assumes the bench commands it on the controller's clock.
`timescale 1ns/10ps
`default_nettype none
module reset_bus_partner (
	input  wire logic clk_i,
	input  wire logic por_cmd_i,
	input  wire logic man_cmd_i,
	input  wire logic breq_cmd_i,
	output logic      power_on_reset_n_o,
	output logic      manual_reset_n_o,
	output logic      bus_req_o
);
	// Pins follow the commands one edge late, like a slow board source.
	// They settle inactive at the first edge, well inside block reset.
	always @(posedge clk_i) begin
		power_on_reset_n_o <= !por_cmd_i;
		manual_reset_n_o <= !man_cmd_i;
		bus_req_o <= breq_cmd_i;
	end
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the CPU state and mode controller.
// Assumes csc_pkg compiled first and csc_defs.svh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "csc_defs.svh"
module tb;
	import csc_pkg::*;
	logic        clk_i = 1'b0;  // System clock.
	logic        nrst_i = 1'b0; // Block reset, active low.
	logic        por_c = 1'b0, man_c = 1'b0, breq_c = 1'b0;
	logic        wake_i = 1'b0, exc_req_i = 1'b0, exc_return_i = 1'b0;
	logic [31:0] exc_ofs_i = '0, pc_i = '0, wdata_i = '0, rdata_o, rd_v;
	logic [7:0]  addr_i = '0;
	logic        we_i = 1'b0, re_i = 1'b0;
	logic        por_n, man_n, breq;
	cpu_state_t  state_o;
	logic        privilege_bit_o, exec_en_o, sleep_o, standby_o;
	logic        bus_grant_o, periph_rst_o, bus_ctrl_rst, pc_load_o, irq_o;
	logic [31:0] pc_target_o;
	int          fails = 0;
	int          comparisons = 0;

	// The clock toggles every half period of 5 ns.
	always #5 clk_i = !clk_i;

	reset_bus_partner i_partner (.clk_i(clk_i), .por_cmd_i(por_c),
		.man_cmd_i(man_c), .breq_cmd_i(breq_c),
		.power_on_reset_n_o(por_n), .manual_reset_n_o(man_n),
		.bus_req_o(breq));

	cpu_state_ctrl i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
		.power_on_reset_n_i(por_n), .manual_reset_n_i(man_n),
		.bus_req_i(breq), .wake_i(wake_i), .exc_req_i(exc_req_i),
		.exc_ofs_i(exc_ofs_i), .exc_return_i(exc_return_i), .pc_i(pc_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
		.rdata_o(rdata_o), .state_o(state_o),
		.privilege_bit_o(privilege_bit_o), .exec_en_o(exec_en_o),
		.sleep_o(sleep_o), .standby_o(standby_o),
		.bus_grant_o(bus_grant_o), .periph_rst_o(periph_rst_o),
		.external_bus_controller_rst_o(bus_ctrl_rst),
		.pc_load_o(pc_load_o),
		.pc_target_o(pc_target_o), .irq_o(irq_o));

	// Counts a comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic give_verdict();
		if (fails == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		we_i <= 1'b0;
	endtask

	// One-cycle register read; data is taken in the following cycle.
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		re_i <= 1'b0;
		#1 rd_v = rdata_o;
	endtask

	// Waits, bounded, for the target load pulse.
	task automatic wait_load();
		int i;
		i = 0;
		do begin
			@(posedge clk_i);
			#1 i++;
		end while (pc_load_o !== 1'b1 && i < 40);
		chk(pc_load_o, 1'b1);
	endtask

	// Lets a few edges pass and samples after they settle.
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// The watchdog cuts a hang short.
	initial begin
		#200us;
		fails++;
		give_verdict();
	end

	// Main test sequence.
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		wait_load();
		chk(pc_target_o, `CSC_RESET_VEC);
		chk(state_o, ST_EXC);
		chk(privilege_bit_o, 1'b1);
		idle(1);
		chk(exec_en_o, 1'b1);
		rd(`CSC_OFS_SW);
		chk(rd_v, `CSC_SW_RST);
		rd(8'h20);
		chk(rd_v, 32'h0);
		// Exception with base plus offset and saved context.
		wr(`CSC_OFS_VBR, 32'h1000);
		@(posedge clk_i);
		pc_i <= 32'h1234;
		exc_ofs_i <= 32'h40;
		exc_req_i <= 1'b1;
		wait_load();
		chk(pc_target_o, 32'h1040);
		@(posedge clk_i);
		exc_req_i <= 1'b0;
		#1 chk(state_o, ST_EXEC);
		rd(`CSC_OFS_SAVED_PC);
		chk(rd_v, 32'h1234);
		rd(`CSC_OFS_SSW);
		chk(rd_v, `CSC_SW_RST);
		// Return drops to user mode and reloads the saved PC.
		@(posedge clk_i);
		exc_return_i <= 1'b1;
		@(posedge clk_i);
		exc_return_i <= 1'b0;
		#1 chk(privilege_bit_o, 1'b0);
		chk(pc_target_o, 32'h1234);
		// The state register stays open to user mode.
		rd(`CSC_OFS_STATE);
		chk(rd_v, 32'h3);
		// User access is refused and raises a violation.
		rd(`CSC_OFS_SW);
		chk(rd_v, 32'h0);
		wait_load();
		chk(pc_target_o, 32'h1000 + `CSC_VIOL_OFS);
		chk(privilege_bit_o, 1'b1);
		// Interrupt masked, unmasked, then cleared.
		wr(`CSC_OFS_IMASK, 32'h0);
		idle(1);
		chk(irq_o, 1'b0);
		wr(`CSC_OFS_IMASK, 32'h4);
		idle(1);
		chk(irq_o, 1'b1);
		wr(`CSC_OFS_ISTAT, 32'hf);
		idle(1);
		chk(irq_o, 1'b0);
		// Bus release held while the requester owns the bus.
		@(posedge clk_i);
		breq_c <= 1'b1;
		idle(12);
		chk(state_o, ST_BUSREL);
		chk(bus_grant_o, 1'b1);
		chk(exec_en_o, 1'b0);
		@(posedge clk_i);
		breq_c <= 1'b0;
		idle(8);
		chk(state_o, ST_EXEC);
		// Standby and sleep halt execution.
		wr(`CSC_OFS_CTRL, 32'h3);
		idle(1);
		chk({standby_o, sleep_o, exec_en_o}, 3'b100);
		@(posedge clk_i);
		wake_i <= 1'b1;
		@(posedge clk_i);
		wake_i <= 1'b0;
		idle(1);
		chk(state_o, ST_EXEC);
		wr(`CSC_OFS_CTRL, 32'h1);
		idle(1);
		chk({standby_o, sleep_o, exec_en_o}, 3'b010);
		// Both resets together, then manual alone.
		@(posedge clk_i);
		por_c <= 1'b1;
		man_c <= 1'b1;
		idle(8);
		chk(state_o, ST_RESET);
		chk({periph_rst_o, bus_ctrl_rst}, 2'b11);
		@(posedge clk_i);
		por_c <= 1'b0;
		idle(8);
		chk(state_o, ST_RESET);
		chk({periph_rst_o, bus_ctrl_rst}, 2'b10);
		@(posedge clk_i);
		man_c <= 1'b0;
		wait_load();
		chk(pc_target_o, `CSC_RESET_VEC);
		rd(`CSC_OFS_VBR);
		chk(rd_v, `CSC_VBR_RST);
		give_verdict();
	end
endmodule
`default_nettype wire
